// ==== rtl/mi_pkg.sv ====
/*
 * Shared constants, encodings and carrier types of the microstep indexer.
 * Assumes a 200 MHz system clock; blanking figures are turned into cycles here, off-time ones in the indexer.
 */
package mi_pkg;

    // Clock and time figures
    localparam int CLK_PERIOD_NS = 5;
    localparam int T_OFF_10_NS = 10000;
    localparam int T_OFF_20_NS = 20000;
    localparam int T_OFF_30_NS = 30000;
    localparam int T_BLANK_18_NS = 1800;
    localparam int T_BLANK_15_NS = 1500;
    localparam int T_BLANK_12_NS = 1200;
    localparam int T_BLANK_09_NS = 900;
    localparam logic [8:0] BLANK_18_CYC = 9'((T_BLANK_18_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [8:0] BLANK_15_CYC = 9'((T_BLANK_15_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [8:0] BLANK_12_CYC = 9'((T_BLANK_12_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [8:0] BLANK_09_CYC = 9'((T_BLANK_09_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Indexer position and current scale
    localparam logic [5:0] HOME_POS = 6'h08;
    localparam logic [5:0] QUARTER_TURN = 6'h10;
    localparam logic [6:0] FULL_SCALE = 7'h64;
    localparam logic [6:0] BLANK_TH_HI = 7'h4B;
    localparam logic [6:0] BLANK_TH_MID = 7'h32;
    localparam logic [6:0] BLANK_TH_LO = 7'h19;
    localparam logic [6:0] ADAPT_FAST_DROP = 7'h10;

    // Register map
    localparam logic [7:0] CTRL_OFFS = 8'h00;
    localparam logic [7:0] STATUS_OFFS = 8'h04;
    localparam logic [10:0] CTRL_RESET = 11'h000;
    localparam int CTRL_RES_LOW_LSB = 0;
    localparam int CTRL_RES_HIGH_LSB = 2;
    localparam int CTRL_TRQ_LOW_BIT = 4;
    localparam int CTRL_TRQ_HIGH_BIT = 5;
    localparam int CTRL_CHOP_OFF_TIME_SELECT_LSB = 6;
    localparam int CTRL_DECAY_LSB = 8;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Three-level pin value: bit 1 set means floating
    typedef enum logic [1:0] {
        LVL_LOW = 2'b00,
        LVL_HIGH = 2'b01,
        LVL_FLOAT = 2'b10
    } mi_level_t;

    typedef enum logic [2:0] {
        RES_FULL = 3'b000,
        RES_NC_HALF = 3'b001,
        RES_HALF = 3'b010,
        RES_QUARTER = 3'b011,
        RES_EIGHTH = 3'b100,
        RES_SIXTEENTH = 3'b101,
        RES_RESERVED = 3'b111
    } mi_res_t;

    typedef enum logic [2:0] {
        DEC_SLOW = 3'b000,
        DEC_SLOW_MIXED = 3'b001,
        DEC_MIXED = 3'b010,
        DEC_SLOW_FAST = 3'b011,
        DEC_FAST = 3'b100,
        DEC_ADAPTIVE = 3'b101
    } mi_decay_mode_t;

    typedef enum logic [1:0] {
        ACT_SLOW = 2'b00,
        ACT_MIXED = 2'b01,
        ACT_FAST = 2'b10
    } mi_decay_act_t;

    // Per-winding command to the current regulator
    typedef struct packed {
        logic [6:0] mag;
        logic fwd;
        mi_decay_act_t decay;
        logic [8:0] blank_cyc;
    } mi_wind_t;

endpackage

// ==== rtl/mi_sine_lut.sv ====
/*
 * Quarter-wave sine lookup for a 64-state electrical cycle.
 * Assumes the angle input is one of 64 states; purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none

module mi_sine_lut import mi_pkg::*; (
    // Angle in 1/64 of a turn
    input wire logic [5:0] angle_i,
    // Magnitude in percent and sign
    output logic [6:0] mag_o,
    output logic neg_o
);

    logic [4:0] idx;

    // Second and fourth quadrants read the table backwards
    assign idx = angle_i[4] ? (5'h10 - {1'b0, angle_i[3:0]}) : {1'b0, angle_i[3:0]};
    assign neg_o = angle_i[5];

    always_comb begin
        case (idx)
            5'h00: mag_o = 7'h00;
            5'h01: mag_o = 7'h0A;
            5'h02: mag_o = 7'h14;
            5'h03: mag_o = 7'h1D;
            5'h04: mag_o = 7'h26;
            5'h05: mag_o = 7'h2F;
            5'h06: mag_o = 7'h38;
            5'h07: mag_o = 7'h3F;
            5'h08: mag_o = 7'h47;
            5'h09: mag_o = 7'h4D;
            5'h0A: mag_o = 7'h53;
            5'h0B: mag_o = 7'h58;
            5'h0C: mag_o = 7'h5C;
            5'h0D: mag_o = 7'h60;
            5'h0E: mag_o = 7'h62;
            default: mag_o = FULL_SCALE;
        endcase
    end

endmodule

`default_nettype wire

// ==== rtl/mi_indexer.sv ====
/*
 * Microstep indexer with step/direction pins and an AXI4-Lite control port.
 * Assumes step, direction and supply flags are synchronous to SYS_CLK_I.
 */
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Both selects low: full step, 71 percent
// - Decode three-level selects into six modes
// - Offer non-circular half step for torque
// - Each step rising edge moves one state, none in reserved mode
// - Direction high forward, low reverse order
// - Mode change: next valid state of new mode
// - Home is the 45 degree state
// - Home after reset, logic undervoltage, sleep
// - Winding A sine, winding B cosine
// - Positive means terminal one to two
// - Decay: slow, slow/mixed, mixed, slow/fast, fast
// - Combined modes: slow rising, other falling
// - Adaptive decay trades ripple against response
// - Off-time selectable 10, 20, 30 us
// - Blanking time shrinks with lower current
// - Motor undervoltage: bridges off, steps kept
// - Torque scaling through digital bits
// - Torque bits give 100/75/50/25 percent
module mi_indexer import mi_pkg::*; #(
    parameter logic [15:0] CHOP_OFF_TIME_SELECT_10_CYC = 16'(T_OFF_10_NS / CLK_PERIOD_NS),
    parameter logic [15:0] CHOP_OFF_TIME_SELECT_20_CYC = 16'(T_OFF_20_NS / CLK_PERIOD_NS),
    parameter logic [15:0] CHOP_OFF_TIME_SELECT_30_CYC = 16'(T_OFF_30_NS / CLK_PERIOD_NS)
) (
    // Clock, reset, enable
    input wire logic SYS_CLK_I,
    input wire logic NRST_I,
    input wire logic CE_I,
    // Motion and supply pins
    input wire logic STEP_I,
    input wire logic DIR_I,
    input wire logic SLEEP_REQUEST_N_I,
    input wire logic LOGIC_UV_I,
    input wire logic MOTOR_SUPPLY_UV_I,
    // AXI4-Lite write
    input wire logic [7:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    // AXI4-Lite read
    input wire logic [7:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    // Current regulator commands
    output mi_wind_t WINDING_A_OUTPUT_O,
    output mi_wind_t WINDING_B_OUTPUT_O,
    output logic BRIDGE_EN_O,
    output logic [15:0] OFF_TIME_CYC_O,
    output logic [5:0] POSITION_O
);

    typedef struct packed {
        logic [5:0] pos;
        logic step_prev;
        logic [10:0] ctrl;
        logic aw_rdy;
        logic w_rdy;
        logic aw_got;
        logic w_got;
        logic [7:0] wr_addr;
        logic [31:0] wr_data;
        logic [3:0] wr_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic ar_rdy;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        mi_wind_t wa;
        mi_wind_t wb;
        logic [3:0] trend;
        logic bridge_en;
        logic [15:0] off_cyc;
    } mi_state_t;

    mi_state_t s_r;
    mi_state_t s_nxt;
    logic step_rise;
    logic awake;
    mi_res_t mode;
    mi_decay_mode_t decay_mode;
    logic [1:0] trq;
    logic [31:0] status_word;
    mi_wind_t wind_nxt [2];
    mi_decay_act_t trend_nxt [2];
    logic [6:0] prev_mag [2];

    function automatic mi_res_t decode_res(input logic [1:0] lo, input logic [1:0] hi);
        mi_res_t r;
        r = RES_RESERVED;
        if (hi[1]) begin
            r = RES_RESERVED;
        end else if (lo[1]) begin
            r = hi[0] ? RES_SIXTEENTH : RES_EIGHTH;
        end else begin
            case ({hi[0], lo[0]})
                2'b00: r = RES_FULL;
                2'b01: r = RES_NC_HALF;
                2'b10: r = RES_HALF;
                default: r = RES_QUARTER;
            endcase
        end
        return r;
    endfunction

    // Fine states moved per step in each mode
    function automatic logic [5:0] step_of(input mi_res_t m);
        logic [5:0] v;
        case (m)
            RES_FULL: v = 6'h10;
            RES_NC_HALF: v = 6'h08;
            RES_HALF: v = 6'h08;
            RES_QUARTER: v = 6'h04;
            RES_EIGHTH: v = 6'h02;
            RES_SIXTEENTH: v = 6'h01;
            default: v = 6'h00;
        endcase
        return v;
    endfunction

    // Snap onto the new grid, then move, except in reverse from off the grid, where the snap is the move; wraps modulo 64
    function automatic logic [5:0] next_pos(input logic [5:0] p, input logic fwd, input mi_res_t m);
        logic [5:0] stp;
        logic [5:0] off;
        logic [5:0] rel;
        logic [5:0] base;
        logic [5:0] r;
        stp = step_of(m);
        off = (m == RES_FULL) ? HOME_POS : 6'h00;
        rel = p - off;
        base = rel & ~(stp - 6'h01);
        if (fwd) begin
            r = base + stp + off;
        end else if (rel == base) begin
            r = base - stp + off;
        end else begin
            r = base + off;
        end
        return r;
    endfunction

    // Pulses are far wider than a clock, so a plain edge detect suffices
    assign step_rise = STEP_I & ~s_r.step_prev;
    assign awake = SLEEP_REQUEST_N_I & ~LOGIC_UV_I;
    assign mode = decode_res(s_r.ctrl[CTRL_RES_LOW_LSB +: 2], s_r.ctrl[CTRL_RES_HIGH_LSB +: 2]);
    assign decay_mode = mi_decay_mode_t'(s_r.ctrl[CTRL_DECAY_LSB +: 3]);
    assign trq = {s_r.ctrl[CTRL_TRQ_HIGH_BIT], s_r.ctrl[CTRL_TRQ_LOW_BIT]};
    assign status_word = {21'h000000, s_r.bridge_en, (mode == RES_RESERVED), mode, s_r.pos};
    assign prev_mag[0] = s_r.wa.mag;
    assign prev_mag[1] = s_r.wb.mag;

    for (genvar g = 0; g < 2; g++) begin : g_wind
        logic [5:0] ang;
        logic [6:0] lut_mag;
        logic lut_neg;
        logic [6:0] raw;
        logic [6:0] scl;
        mi_decay_act_t trd;
        mi_decay_act_t dec;
        logic [8:0] blank;

        // Winding B runs a quarter turn ahead: cosine
        assign ang = s_r.pos + 6'(g * 16);

        mi_sine_lut u_lut (
            .angle_i(ang),
            .mag_o(lut_mag),
            .neg_o(lut_neg)
        );

        always_comb begin
            raw = lut_mag;
            // Diagonal states at full scale give the squarer, stronger wave
            if (mode == RES_NC_HALF && s_r.pos[3:0] == HOME_POS[3:0]) begin
                raw = FULL_SCALE;
            end
            case (trq)
                2'b00: scl = raw;
                2'b01: scl = raw - (raw >> 2);
                2'b10: scl = raw >> 1;
                default: scl = raw >> 2;
            endcase
            // Class of the last move stands until the magnitude moves again
            if (scl == prev_mag[g]) begin
                trd = mi_decay_act_t'(s_r.trend[2*g +: 2]);
            end else if (scl > prev_mag[g]) begin
                trd = ACT_SLOW;
            end else if ((prev_mag[g] - scl) > ADAPT_FAST_DROP) begin
                // Large drops need fast decay to settle; small ones keep ripple low
                trd = ACT_FAST;
            end else begin
                trd = ACT_MIXED;
            end
            case (decay_mode)
                DEC_SLOW: dec = ACT_SLOW;
                DEC_SLOW_MIXED: dec = (trd == ACT_SLOW) ? ACT_SLOW : ACT_MIXED;
                DEC_MIXED: dec = ACT_MIXED;
                DEC_SLOW_FAST: dec = (trd == ACT_SLOW) ? ACT_SLOW : ACT_FAST;
                DEC_FAST: dec = ACT_FAST;
                DEC_ADAPTIVE: dec = trd;
                default: dec = ACT_SLOW;
            endcase
            if (scl >= BLANK_TH_HI) begin
                blank = BLANK_18_CYC;
            end else if (scl >= BLANK_TH_MID) begin
                blank = BLANK_15_CYC;
            end else if (scl >= BLANK_TH_LO) begin
                blank = BLANK_12_CYC;
            end else begin
                blank = BLANK_09_CYC;
            end
        end

        assign wind_nxt[g] = '{mag: scl, fwd: ~lut_neg, decay: dec, blank_cyc: blank};
        assign trend_nxt[g] = trd;
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.step_prev = STEP_I;
        if (!awake) begin
            s_nxt.pos = HOME_POS;
        end else if (step_rise && mode != RES_RESERVED) begin
            s_nxt.pos = next_pos(s_r.pos, DIR_I, mode);
        end
        // Logic keeps counting through a supply dip, only the bridges stop
        s_nxt.bridge_en = awake & ~MOTOR_SUPPLY_UV_I;
        s_nxt.wa = wind_nxt[0];
        s_nxt.wb = wind_nxt[1];
        s_nxt.trend = {trend_nxt[1], trend_nxt[0]};
        case (mi_level_t'(s_r.ctrl[CTRL_CHOP_OFF_TIME_SELECT_LSB +: 2]))
            LVL_LOW: s_nxt.off_cyc = CHOP_OFF_TIME_SELECT_20_CYC;
            LVL_HIGH: s_nxt.off_cyc = CHOP_OFF_TIME_SELECT_30_CYC;
            default: s_nxt.off_cyc = CHOP_OFF_TIME_SELECT_10_CYC;
        endcase
        // Address and data may arrive in either order
        if (s_r.aw_rdy && S_AXI_AWVALID_I) begin
            s_nxt.aw_got = 1'b1;
            s_nxt.wr_addr = S_AXI_AWADDR_I;
        end
        if (s_r.w_rdy && S_AXI_WVALID_I) begin
            s_nxt.w_got = 1'b1;
            s_nxt.wr_data = S_AXI_WDATA_I;
            s_nxt.wr_strb = S_AXI_WSTRB_I;
        end
        if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = RESP_OKAY;
            if (s_r.wr_addr[7:2] == CTRL_OFFS[7:2]) begin
                if (s_r.wr_strb[0]) begin
                    s_nxt.ctrl[7:0] = s_r.wr_data[7:0];
                end
                if (s_r.wr_strb[1]) begin
                    s_nxt.ctrl[10:8] = s_r.wr_data[10:8];
                end
            end else if (s_r.wr_addr[7:2] == STATUS_OFFS[7:2]) begin
                s_nxt.bresp = RESP_OKAY;
            end else begin
                s_nxt.bresp = RESP_SLVERR;
            end
        end else if (s_r.bvalid && S_AXI_BREADY_I) begin
            s_nxt.bvalid = 1'b0;
        end
        s_nxt.aw_rdy = ~s_nxt.aw_got & ~s_nxt.bvalid;
        s_nxt.w_rdy = ~s_nxt.w_got & ~s_nxt.bvalid;
        if (s_r.ar_rdy && S_AXI_ARVALID_I) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = RESP_OKAY;
            if (S_AXI_ARADDR_I[7:2] == CTRL_OFFS[7:2]) begin
                s_nxt.rdata = {21'h000000, s_r.ctrl};
            end else if (S_AXI_ARADDR_I[7:2] == STATUS_OFFS[7:2]) begin
                s_nxt.rdata = status_word;
            end else begin
                s_nxt.rdata = 32'h00000000;
                s_nxt.rresp = RESP_SLVERR;
            end
        end else if (s_r.rvalid && S_AXI_RREADY_I) begin
            s_nxt.rvalid = 1'b0;
        end
        s_nxt.ar_rdy = ~s_nxt.rvalid;
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!NRST_I) begin
            s_r <= '0;
            s_r.pos <= HOME_POS;
            s_r.ctrl <= CTRL_RESET;
            s_r.step_prev <= 1'b1;
            s_r.off_cyc <= CHOP_OFF_TIME_SELECT_20_CYC;
        end else if (CE_I) begin
            s_r <= s_nxt;
        end
    end

    assign S_AXI_AWREADY_O = s_r.aw_rdy;
    assign S_AXI_WREADY_O = s_r.w_rdy;
    assign S_AXI_BRESP_O = s_r.bresp;
    assign S_AXI_BVALID_O = s_r.bvalid;
    assign S_AXI_ARREADY_O = s_r.ar_rdy;
    assign S_AXI_RDATA_O = s_r.rdata;
    assign S_AXI_RRESP_O = s_r.rresp;
    assign S_AXI_RVALID_O = s_r.rvalid;
    assign WINDING_A_OUTPUT_O = s_r.wa;
    assign WINDING_B_OUTPUT_O = s_r.wb;
    assign BRIDGE_EN_O = s_r.bridge_en;
    assign OFF_TIME_CYC_O = s_r.off_cyc;
    assign POSITION_O = s_r.pos;

    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (!NRST_I);

    property p_home;
        CE_I && !SLEEP_REQUEST_N_I |=> s_r.pos == HOME_POS;
    endproperty
    a_home: assert property (p_home) else $error("not home after sleep");

    property p_full_grid;
        CE_I && awake && step_rise && mode == RES_FULL |=> s_r.pos[3:0] == 4'h8;
    endproperty
    a_full_grid: assert property (p_full_grid) else $error("full step off diagonal");

    property p_fwd16;
        CE_I && awake && step_rise && DIR_I && mode == RES_SIXTEENTH |=> s_r.pos == $past(s_r.pos) + 6'h01;
    endproperty
    a_fwd16: assert property (p_fwd16) else $error("forward fine step wrong");

    property p_rev_half;
        CE_I && awake && step_rise && !DIR_I && mode == RES_HALF && s_r.pos[2:0] == 3'h0
            |=> s_r.pos == $past(s_r.pos) - 6'h08;
    endproperty
    a_rev_half: assert property (p_rev_half) else $error("reverse half step wrong");

    property p_quarter_grid;
        CE_I && awake && step_rise && mode == RES_QUARTER |=> s_r.pos[1:0] == 2'h0;
    endproperty
    a_quarter_grid: assert property (p_quarter_grid) else $error("off quarter grid");

    property p_hold;
        CE_I && awake && (!step_rise || mode == RES_RESERVED) |=> $stable(s_r.pos);
    endproperty
    a_hold: assert property (p_hold) else $error("moved without step");

    property p_uv;
        CE_I && awake && MOTOR_SUPPLY_UV_I |=> !BRIDGE_EN_O
            && (s_r.pos != $past(s_r.pos) || !$past(step_rise) || $past(mode) == RES_RESERVED);
    endproperty
    a_uv: assert property (p_uv) else $error("undervoltage handling wrong");

    property p_trq25;
        CE_I && trq == 2'b11 |=> WINDING_A_OUTPUT_O.mag <= BLANK_TH_LO && WINDING_B_OUTPUT_O.mag <= BLANK_TH_LO;
    endproperty
    a_trq25: assert property (p_trq25) else $error("torque scale exceeded");

    property p_sine;
        CE_I && s_r.pos == QUARTER_TURN && trq == 2'b00 |=> WINDING_A_OUTPUT_O.mag == FULL_SCALE
            && WINDING_A_OUTPUT_O.fwd && WINDING_B_OUTPUT_O.mag == 7'h00;
    endproperty
    a_sine: assert property (p_sine) else $error("sine/cosine targets wrong");

    property p_slow;
        CE_I && decay_mode == DEC_SLOW |=> WINDING_A_OUTPUT_O.decay == ACT_SLOW;
    endproperty
    a_slow: assert property (p_slow) else $error("decay not slow");

    c_fwd_fine: cover property (CE_I && awake && step_rise && DIR_I && mode == RES_SIXTEENTH);
    c_rev_full: cover property (CE_I && awake && step_rise && !DIR_I && mode == RES_FULL);
    c_write: cover property (S_AXI_BVALID_O && S_AXI_BREADY_I && S_AXI_BRESP_O == RESP_OKAY);

endmodule

`default_nettype wire

// ==== test/mi_step_ctl.sv ====
/*
 * Motion controller model: one step pulse per request, direction set first.
 * Assumes requests come from the bench on the rising clock edge.
 */
`timescale 1ns/1ps
`default_nettype none

module mi_step_ctl (
    // Clock and request
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic dir_req_i,
    // Pins toward the indexer
    output logic step_o,
    output logic dir_o,
    output logic busy_o
);
    logic [2:0] cnt_r = 3'h0;
    initial begin
        step_o = 1'h0;
        dir_o = 1'h1;
    end
    assign busy_o = (cnt_r != 3'h0);
    always @(posedge clk_i) begin
        if (go_i && !busy_o) begin
            // Direction leads the edge so setup holds
            dir_o <= dir_req_i;
            cnt_r <= 3'h6;
        end else if (busy_o) begin
            cnt_r <= cnt_r - 3'h1;
            // High two cycles, low three: never near the top rate
            step_o <= (cnt_r == 3'h5) || (cnt_r == 3'h4);
        end
    end
endmodule

`default_nettype wire

// ==== test/mi_indexer_tb.sv ====
/*
 * Self-checking bench of the microstep indexer: registers over AXI4-Lite,
 * steps through the controller model. Assumes shortened off-time counts.
 */
`timescale 1ns/1ps
`default_nettype none

module mi_indexer_tb;
    import mi_pkg::*;
    logic clk = 1'h0;
    logic nrst = 1'h0;
    logic sleep_n = 1'h1, luv = 1'h0, muv = 1'h0, go = 1'h0, dreq = 1'h1, ce = 1'h1;
    logic step, dir, busy, ben, awr, wr, bv, arr, rv;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic awv = 1'h0, wv = 1'h0, bready = 1'h0, arv = 1'h0, rready = 1'h0;
    logic [1:0] bresp, rresp, lastb;
    mi_wind_t wa, wb;
    logic [15:0] chop_off_time_select;
    logic [5:0] pos;
    logic [33:0] exp_q[$];
    logic [31:0] msk_q[$];
    int errors = 0, checked = 0;
    integer seed = 32'hDF90481F;

    always #2.5 clk = ~clk;

    mi_step_ctl mi_step_ctl_i (.clk_i(clk), .go_i(go), .dir_req_i(dreq), .step_o(step), .dir_o(dir),
        .busy_o(busy));
    mi_indexer #(.CHOP_OFF_TIME_SELECT_10_CYC(16'h14), .CHOP_OFF_TIME_SELECT_20_CYC(16'h28), .CHOP_OFF_TIME_SELECT_30_CYC(16'h3C)) mi_indexer_i (
        .SYS_CLK_I(clk), .NRST_I(nrst), .CE_I(ce), .STEP_I(step), .DIR_I(dir),
        .SLEEP_REQUEST_N_I(sleep_n), .LOGIC_UV_I(luv), .MOTOR_SUPPLY_UV_I(muv),
        .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
        .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr),
        .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bready),
        .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
        .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rready),
        .WINDING_A_OUTPUT_O(wa), .WINDING_B_OUTPUT_O(wb), .BRIDGE_EN_O(ben),
        .OFF_TIME_CYC_O(chop_off_time_select), .POSITION_O(pos));

    task automatic conclude;
        if (errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [33:0] got, input logic [33:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Bounded wait ran out: counted, then straight to the verdict
    task automatic hung;
        errors++;
        $display("BAD bus_wait expected answer seen none");
        conclude();
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awv <= 1'h1;
        wv <= 1'h1;
        bready <= 1'h1;
        for (n = 0; n < 200; n++) begin
            @(posedge clk);
            if (awv && awr) awv <= 1'h0;
            if (wv && wr) wv <= 1'h0;
            if (bv) break;
        end
        if (n == 200) hung();
        lastb = bresp;
        bready <= 1'h0;
    endtask

    // Expected value noted first, compared by the watcher
    task automatic axr(input logic [7:0] a, input logic [33:0] e, input logic [31:0] m);
        int n;
        exp_q.push_back(e);
        msk_q.push_back(m);
        @(posedge clk);
        araddr <= a;
        arv <= 1'h1;
        rready <= 1'h1;
        for (n = 0; n < 200; n++) begin
            @(posedge clk);
            if (arv && arr) arv <= 1'h0;
            if (rv) break;
        end
        if (n == 200) hung();
        rready <= 1'h0;
    endtask

    always @(posedge clk) begin
        if (rv && rready && exp_q.size() > 0) begin
            chk("read", {rresp, rdata & msk_q[0]}, exp_q[0]);
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
    end

    task automatic do_step(input logic d);
        @(posedge clk);
        go <= 1'h1;
        dreq <= d;
        @(posedge clk);
        go <= 1'h0;
        repeat (12) @(posedge clk);
    endtask

    function automatic logic [33:0] st(input logic [5:0] p, input logic [2:0] m, input logic b);
        return {RESP_OKAY, 21'h0, b, m == 3'h7, m, p};
    endfunction

    initial begin
        logic [3:0] codes[7];
        logic [6:0] tq[4];
        logic [15:0] offs[3];
        logic [31:0] ctl[4];
        logic [1:0] dex[4];
        logic [5:0] p;
        logic d;
        int i;
        codes = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h2, 4'h6, 4'h8};
        tq = '{7'h47, 7'h36, 7'h23, 7'h11};
        offs = '{16'h28, 16'h3C, 16'h14};
        ctl = '{32'h530, 32'h200, 32'h130, 32'h400};
        dex = '{ACT_FAST, ACT_MIXED, ACT_MIXED, ACT_FAST};
        repeat (20) @(posedge clk);
        nrst <= 1'h1;
        repeat (2) @(posedge clk);
        axr(STATUS_OFFS, st(HOME_POS, 3'h0, 1'h1), 32'h7FF);
        chk("mag_a", wa.mag, 7'h47);
        chk("mag_b", wb.mag, 7'h47);
        for (i = 0; i < 7; i++) begin
            axw(CTRL_OFFS, {28'h0, codes[i]});
            axr(STATUS_OFFS, st(6'h0, (i == 6) ? 3'h7 : 3'(i), 1'h0), 32'h3C0);
            if (i == 1) chk("nc_half", wa.mag, FULL_SCALE);
        end
        do_step(1'h1);
        axr(STATUS_OFFS, st(HOME_POS, 3'h0, 1'h0), 32'h3F);
        axw(CTRL_OFFS, 32'h306);
        do_step(1'h1);
        axr(STATUS_OFFS, st(6'h09, 3'h0, 1'h0), 32'h3F);
        chk("mag_a", wa.mag, 7'h4D);
        chk("mag_b", wb.mag, 7'h3F);
        chk("fwd_a", wa.fwd, 1'h1);
        chk("dec_a", wa.decay, ACT_SLOW);
        chk("dec_b", wb.decay, ACT_FAST);
        do_step(1'h0);
        do_step(1'h0);
        axr(STATUS_OFFS, st(6'h07, 3'h0, 1'h0), 32'h3F);
        p = 6'h07;
        // Random walk keeps every direction change in play
        for (i = 0; i < 20; i++) begin
            d = 1'($random(seed));
            do_step(d);
            p = d ? p + 6'h1 : p - 6'h1;
        end
        axr(STATUS_OFFS, st(p, 3'h0, 1'h0), 32'h3F);
        // Enable low: a whole pulse inside the freeze is lost
        ce <= 1'h0;
        do_step(1'h1);
        ce <= 1'h1;
        axr(STATUS_OFFS, st(p, 3'h0, 1'h0), 32'h3F);
        axw(CTRL_OFFS, 32'h0);
        do_step(1'h1);
        p = 6'((({1'h0, p} + 7'h08) >> 4) << 4) + 6'h08;
        axr(STATUS_OFFS, st(p, 3'h0, 1'h0), 32'h3F);
        for (i = 0; i < 4; i++) do_step(1'h1);
        axr(STATUS_OFFS, st(p, 3'h0, 1'h0), 32'h3F);
        muv <= 1'h1;
        do_step(1'h1);
        axr(STATUS_OFFS, st(p + QUARTER_TURN, 3'h0, 1'h0), 32'h43F);
        chk("bridge", ben, 1'h0);
        muv <= 1'h0;
        sleep_n <= 1'h0;
        repeat (3) @(posedge clk);
        axr(STATUS_OFFS, st(HOME_POS, 3'h0, 1'h0), 32'h43F);
        sleep_n <= 1'h1;
        do_step(1'h1);
        axr(STATUS_OFFS, st(6'h18, 3'h0, 1'h1), 32'h43F);
        luv <= 1'h1;
        repeat (3) @(posedge clk);
        luv <= 1'h0;
        repeat (3) @(posedge clk);
        axr(STATUS_OFFS, st(HOME_POS, 3'h0, 1'h1), 32'h43F);
        for (i = 0; i < 4; i++) begin
            axw(CTRL_OFFS, 32'(i) << 4);
            repeat (4) @(posedge clk);
            chk("torque", wa.mag, tq[i]);
        end
        for (i = 0; i < 3; i++) begin
            axw(CTRL_OFFS, 32'(i) << 6);
            repeat (3) @(posedge clk);
            chk("off_time", chop_off_time_select, offs[i]);
        end
        for (i = 0; i < 4; i++) begin
            axw(CTRL_OFFS, ctl[i]);
            repeat (3) @(posedge clk);
            chk("decay", wa.decay, dex[i]);
        end
        axr(8'h08, {RESP_SLVERR, 32'h0}, 32'hFFFFFFFF);
        axw(8'h0C, 32'h5);
        chk("bresp", lastb, RESP_SLVERR);
        repeat (4) @(posedge clk);
        conclude();
    end
endmodule

`default_nettype wire
